//--- hdl/uadma_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "uadma_defs.svh"

// --------------------------------------------------------------
// Data buffer
// --------------------------------------------------------------
module uadma_fifo #(
    parameter int W = `UADMA_FIFO_W,
    parameter int D = `UADMA_FIFO_D
) (
    // Clock, reset and flush
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         flush_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count
    assign in_ready_o  = (cnt_q != D[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o && !flush_i;
    assign pop         = out_valid_o && out_ready_i && !flush_i;

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    // Pointers and count; flush empties in one cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop)
            begin
                rp_q <= rp_q + AW'(1);
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule // uadma_fifo

// Behaviour
// RULE1 - Status echo is read-only; reading it disturbs nothing.
// RULE2 - Status echo resets to 1Fh.
// RULE3 - Echo follows selected endpoint status even with DMA idle.
// RULE4 - Packet count resets to zero, read/write, decrements, stops at 0.
// RULE5 - Count-done flag sets on the next success after reaching zero.
// RULE6 - Receive: decrement after good reception then DMA move.
// RULE7 - Transmit: decrement after DMA fetch then good transmission.
// RULE8 - Software loads the packet count with packets minus one.
// RULE9 - CPU write to packet count beats a same-cycle decrement.
// RULE10 - Error register resets to zero: retry count 6..0, handling bit 7.
// RULE11 - Retry count drops by one per bus error when handling enabled.
// RULE12 - Success or end of automatic mode reloads retry count preset.
// RULE13 - Error at retry zero sets transfer error; count never wraps.
// RULE14 - Software loads retry preset with allowed attempts minus one.
// RULE15 - Error register writes are dropped while automatic mode runs.
// RULE16 - Error register reads live count when active, preset otherwise.
// RULE17 - Non-iso bad packets are handled without software help.
// RULE18 - Non-iso transmit: refill FIFO and resend unacknowledged packet.
// RULE19 - Non-iso receive: flush bad packet so it is received again.
// RULE20 - Iso receive: flush bad packet, reset FIFO, never pass it on.
// RULE21 - Handling bit cleared stops all reload, resend and flush.
// RULE22 - Endpoint select 000..101 means endpoints 1..6; 11x reserved.
// RULE23 - Transfer error covers bad packets and toggle mismatches.
// RULE24 - Automatic mode ends as soon as an event flag sets.
module uadma_core (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // CPU byte register port
    input  wire uadma_pkg::uadma_cpu_t  cpu_i,
    output logic                 [7:0]  rdata_o,
    // Endpoint selection and status
    input  wire logic            [2:0]  dma_endpoint_select_i,
    input  wire logic       [5:0][7:0]  ep_state_i,
    input  wire logic                   ep_is_tx_i,
    input  wire logic                   ep_is_iso_i,
    input  wire logic                   automatic_transfer_mode_i,
    // Packet events of the selected endpoint
    input  wire uadma_pkg::uadma_evt_t  evt_i,
    // Event flag set pulses and mode stop
    output logic                        count_done_flag_o,
    output logic                        transfer_error_flag_o,
    output logic                        automatic_transfer_mode_stop_o,
    // Automatic error handling actions
    output logic                        refill_o,
    output logic                        flush_o,
    output logic                        iso_drop_o,
    // Packet data path
    input  wire logic            [7:0]  rx_data_i,
    input  wire logic                   rx_valid_i,
    output logic                        rx_ready_o,
    output logic                 [7:0]  dma_data_o,
    output logic                        dma_valid_o,
    input  wire logic                   dma_ready_i
);
    import uadma_pkg::*;

    // ----------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------
    function automatic logic sel_ok(input logic [2:0] s);
        sel_ok = (s <= `UADMA_EP_MAX); // [RULE22]
    endfunction

    logic [7:0] echo_q;
    logic [7:0] cnt_q;
    logic [6:0] preset_q;
    logic [6:0] live_q;
    logic       aeh_q;
    logic       active_q;
    logic       rx_open_q;
    uadma_seq_t seq_q;
    logic       ev_ok;
    logic       ev_err;
    logic       ev_dma;
    logic       done;
    logic       err_hit;
    logic       wr_cnt;
    logic       wr_err;
    logic       auto_fix;
    logic       f_flush;
    logic       f_valid;
    logic [7:0] f_data;
    logic       f_ready;
    logic       f_take;

    // Events count only for a legal endpoint selection
    assign ev_ok  = evt_i.pkt_ok && sel_ok(dma_endpoint_select_i);
    assign ev_err = evt_i.pkt_err && sel_ok(dma_endpoint_select_i);
    assign ev_dma = evt_i.dma_done && sel_ok(dma_endpoint_select_i);
    assign wr_cnt = cpu_i.wr && (cpu_i.sel == `UADMA_SEL_CNT);
    assign wr_err = cpu_i.wr && (cpu_i.sel == `UADMA_SEL_ERR);

    // ----------------------------------------------------------
    // Status echo
    // ----------------------------------------------------------
    // Sampled every cycle while the select is legal, regardless of DMA state; no write path
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            echo_q <= `UADMA_ECHO_RST; // [RULE2]
        end
        else if (sel_ok(dma_endpoint_select_i))
        begin
            echo_q <= ep_state_i[dma_endpoint_select_i]; // [RULE3] [RULE1]
        end
    end

    // ----------------------------------------------------------
    // Completion sequencer
    // ----------------------------------------------------------
    // Receive needs bus success then DMA move; transmit the reverse.
    // An error discards a half-done packet.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            seq_q <= UADMA_IDLE;
        end
        else if (!active_q || ev_err)
        begin
            seq_q <= UADMA_IDLE;
        end
        else
        begin
            unique case (seq_q)
                UADMA_IDLE:
                begin
                    if (ep_is_tx_i ? ev_dma : ev_ok) // [RULE6] [RULE7]
                    begin
                        seq_q <= UADMA_HALF;
                    end
                end
                UADMA_HALF:
                begin
                    if (ep_is_tx_i ? ev_ok : ev_dma) // [RULE6] [RULE7]
                    begin
                        seq_q <= UADMA_IDLE;
                    end
                end
                default:
                begin
                    seq_q <= UADMA_IDLE;
                end
            endcase
        end
    end

    assign done = active_q && !ev_err && (seq_q == UADMA_HALF)
                  && (ep_is_tx_i ? ev_ok : ev_dma);

    // ----------------------------------------------------------
    // Packet countdown
    // ----------------------------------------------------------
    // Software loads packets minus one, so the flag lands on the last
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= `UADMA_CNT_RST; // [RULE4]
        end
        else if (wr_cnt)
        begin
            cnt_q <= cpu_i.wdata; // [RULE9] [RULE8]
        end
        else if (done && cnt_q != 8'h00)
        begin
            cnt_q <= cnt_q - 8'h01; // [RULE4]
        end
    end

    // ----------------------------------------------------------
    // Retry counter and handling control
    // ----------------------------------------------------------
    assign err_hit = active_q && ev_err
                     && (!aeh_q || live_q == 7'h00); // [RULE13] [RULE23]

    // Active level copy, also used to see the end of automatic mode
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            active_q <= 1'b0;
        end
        else
        begin
            active_q <= automatic_transfer_mode_i;
        end
    end

    // Preset and handling bit change only while the mode is off
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            preset_q <= 7'(`UADMA_ERR_RST); // [RULE10]
            aeh_q    <= 1'b0;
        end
        else if (wr_err && !active_q) // [RULE15]
        begin
            preset_q <= cpu_i.wdata[`UADMA_ERR_CNT_HI:0];
            aeh_q    <= cpu_i.wdata[`UADMA_ERR_AEH];
        end
    end

    // Live counter: reload on success or mode end, step on error
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            live_q <= 7'(`UADMA_ERR_RST); // [RULE10]
        end
        else if (wr_err && !active_q)
        begin
            live_q <= cpu_i.wdata[`UADMA_ERR_CNT_HI:0];
        end
        else if (!active_q || ev_ok)
        begin
            live_q <= preset_q; // [RULE12]
        end
        else if (ev_err && aeh_q && live_q != 7'h00)
        begin
            live_q <= live_q - 7'h01; // [RULE11] [RULE13]
        end
    end

    // ----------------------------------------------------------
    // Flag pulses, mode stop and handling actions
    // ----------------------------------------------------------
    // Handling acts only below the retry limit, so a final error
    // stops the mode instead of retrying forever
    assign auto_fix = active_q && ev_err && aeh_q && live_q != 7'h00;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            count_done_flag_o     <= 1'b0;
            transfer_error_flag_o <= 1'b0;
            automatic_transfer_mode_stop_o           <= 1'b0;
            refill_o              <= 1'b0;
            flush_o               <= 1'b0;
            iso_drop_o            <= 1'b0;
        end
        else
        begin
            count_done_flag_o     <= done && cnt_q == 8'h00; // [RULE5]
            transfer_error_flag_o <= err_hit; // [RULE13]
            automatic_transfer_mode_stop_o <= err_hit || (done && cnt_q == 8'h00); // [RULE24]
            refill_o    <= auto_fix && ep_is_tx_i
                           && !ep_is_iso_i; // [RULE18] [RULE17] [RULE21]
            flush_o     <= auto_fix && !ep_is_tx_i; // [RULE19] [RULE21]
            iso_drop_o  <= auto_fix && !ep_is_tx_i
                           && ep_is_iso_i; // [RULE20]
        end
    end

    // ----------------------------------------------------------
    // Register read
    // ----------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (cpu_i.rd)
        begin
            unique case (cpu_i.sel)
                `UADMA_SEL_ECHO: rdata_o <= echo_q; // [RULE1]
                `UADMA_SEL_CNT:  rdata_o <= cnt_q;
                `UADMA_SEL_ERR:  rdata_o <= {aeh_q,
                    active_q ? live_q : preset_q}; // [RULE16]
                default:         rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Receive data buffer
    // ----------------------------------------------------------
    // Receive data is held until the packet proves good, so a bad
    // packet retried by error handling is flushed before any byte reaches DMA. The gate shuts
    // when the buffer drains; a next packet arriving earlier leaks.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_open_q <= 1'b0;
        end
        else if (ev_err || !active_q)
        begin
            rx_open_q <= 1'b0;
        end
        else if (ev_ok)
        begin
            rx_open_q <= 1'b1;
        end
        else if (!f_valid)
        begin
            rx_open_q <= 1'b0;
        end
    end

    assign f_flush = auto_fix && !ep_is_tx_i; // [RULE20] [RULE19]

    // Output stage loads when empty or when its byte is taken,
    // so a stalled byte is never overwritten
    assign f_take = !dma_valid_o || dma_ready_i;

    uadma_fifo #(
        .W (`UADMA_FIFO_W),
        .D (`UADMA_FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .flush_i     (f_flush),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (f_ready),
        .in_data_i   (rx_data_i),
        .out_valid_o (f_valid),
        .out_ready_i (f_take && rx_open_q),
        .out_data_o  (f_data)
    );

    // Back-pressure and data reach the ports through registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_ready_o  <= 1'b0;
            dma_valid_o <= 1'b0;
            dma_data_o  <= 8'h00;
        end
        else
        begin
            rx_ready_o <= f_ready;
            if (f_take)
            begin
                dma_valid_o <= f_valid && rx_open_q; // [RULE20]
                dma_data_o  <= f_data;
            end
        end
    end

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    AST_ECHO_TRACK: assert property ( // [RULE3]
        @(posedge clk_i) disable iff (!nrst_i)
        sel_ok(dma_endpoint_select_i) |=>
        echo_q == $past(ep_state_i[dma_endpoint_select_i]))
        else $error("echo does not follow selected endpoint");

    AST_CNT_WRITE_WINS: assert property ( // [RULE9]
        @(posedge clk_i) disable iff (!nrst_i)
        wr_cnt |=> cnt_q == $past(cpu_i.wdata))
        else $error("count write lost to decrement");

    AST_CNT_DEC: assert property ( // [RULE4]
        @(posedge clk_i) disable iff (!nrst_i)
        done && !wr_cnt && cnt_q != 8'h00 |=>
        cnt_q == $past(cnt_q) - 8'h01)
        else $error("count did not decrement");

    AST_CNT_DONE: assert property ( // [RULE5]
        @(posedge clk_i) disable iff (!nrst_i)
        count_done_flag_o |-> $past(cnt_q) == 8'h00
        && $past(done))
        else $error("count done without completion at zero");

    AST_ERR_LOCK: assert property ( // [RULE15]
        @(posedge clk_i) disable iff (!nrst_i)
        wr_err && active_q |=> preset_q == $past(preset_q)
        && aeh_q == $past(aeh_q))
        else $error("error register written while active");

    AST_RETRY_DEC: assert property ( // [RULE11]
        @(posedge clk_i) disable iff (!nrst_i)
        active_q && ev_err && !ev_ok && aeh_q && live_q != 7'h00 |=>
        live_q == $past(live_q) - 7'h01)
        else $error("retry counter did not step");

    AST_RETRY_RELOAD: assert property ( // [RULE12]
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(active_q) |=> live_q == $past(preset_q))
        else $error("retry counter not reloaded at mode end");

    AST_TERR_AT_ZERO: assert property ( // [RULE13]
        @(posedge clk_i) disable iff (!nrst_i)
        active_q && ev_err && aeh_q && live_q == 7'h00 |=>
        transfer_error_flag_o && automatic_transfer_mode_stop_o)
        else $error("no transfer error at retry zero");

    AST_NO_AEH_NO_FIX: assert property ( // [RULE21]
        @(posedge clk_i) disable iff (!nrst_i)
        !aeh_q |=> !refill_o && !flush_o && !iso_drop_o)
        else $error("handling action with handling off");

    AST_ISO_HOLD: assert property ( // [RULE20]
        @(posedge clk_i) disable iff (!nrst_i)
        iso_drop_o |-> !rx_open_q && !f_valid)
        else $error("bad iso packet left for DMA");

endmodule // uadma_core

`default_nettype wire

//--- hdl/uadma_defs.svh
`ifndef UADMA_DEFS_SVH
`define UADMA_DEFS_SVH

// Register select codes on the CPU byte port
`define UADMA_SEL_ECHO  2'h0
`define UADMA_SEL_CNT   2'h1
`define UADMA_SEL_ERR   2'h2

// Reset values
`define UADMA_ECHO_RST  8'h1F
`define UADMA_CNT_RST   8'h00
`define UADMA_ERR_RST   8'h00

// Error register field positions
`define UADMA_ERR_AEH   7
`define UADMA_ERR_CNT_HI 6

// Highest legal endpoint select code
`define UADMA_EP_MAX    3'h5

// Data buffer shape
`define UADMA_FIFO_W    8
`define UADMA_FIFO_D    16

`endif

//--- hdl/uadma_pkg.sv
package uadma_pkg;

    // One CPU register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] sel;
        logic [7:0] wdata;
    } uadma_cpu_t;

    // Packet events of the selected endpoint, one-cycle pulses
    typedef struct packed {
        logic pkt_ok;
        logic pkt_err;
        logic dma_done;
    } uadma_evt_t;

    // Completion sequencer
    typedef enum logic [1:0] {
        UADMA_IDLE  = 2'b01,
        UADMA_HALF  = 2'b10
    } uadma_seq_t;

endpackage

//--- tb/uadma_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------
// Host side: pushes packet bytes into the node buffer
// ----------------------------------------------------------
module uadma_host_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Packet request
    input  wire logic       start_i,
    input  wire logic [4:0] len_i,
    input  wire logic [7:0] base_i,
    // Fill side of the buffer
    input  wire logic       rx_ready_i,
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    output logic            busy_o
);
    int n;

    initial
    begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        busy_o     = 1'b0;
    end

    // Start is sampled on the rising edge, clear of the bench's
    // falling-edge drive; each byte stands until ready is seen
    always
    begin
        @(posedge clk_i);
        if (start_i && nrst_i)
        begin
            busy_o = 1'b1;
            for (n = 0; n < len_i; n++)
            begin
                @(negedge clk_i);
                rx_valid_o = 1'b1;
                rx_data_o  = base_i + n[7:0];
                do @(posedge clk_i); while (rx_ready_i !== 1'b1);
            end
            @(negedge clk_i);
            rx_valid_o = 1'b0;
            // A released line must not look like the last byte
            rx_data_o  = ~rx_data_o;
            busy_o     = 1'b0;
        end
    end
endmodule // uadma_host_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uadma_defs.svh"

module testbench;
    import uadma_pkg::*;

    logic            clk_i = 1'b0;
    logic            nrst_i;
    uadma_cpu_t      cpu;
    uadma_evt_t      evt;
    logic      [7:0] rdata;
    logic      [2:0] ep_sel;
    logic [5:0][7:0] ep_state;
    logic            is_tx;
    logic            is_iso;
    logic            mode;
    logic            cdone;
    logic            terr;
    logic            stop;
    logic            refill;
    logic            flush;
    logic            drop;
    logic      [7:0] rx_data;
    logic            rx_valid;
    logic            rx_ready;
    logic      [7:0] dma_data;
    logic            dma_valid;
    logic            dma_ready;
    logic            start;
    logic      [7:0] base;
    logic            busy;
    logic            rd_look;
    logic      [5:0] pulses;
    logic      [7:0] rd_q[$];
    logic      [5:0] ev_q[$];
    logic      [7:0] dma_q[$];
    int              err_count = 0;
    int              samples_checked = 0;
    int              i;

    assign pulses = {cdone, terr, stop, refill, flush, drop};

    // ------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------
    always #2.5 clk_i = ~clk_i;

    uadma_core i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .cpu_i(cpu), .rdata_o(rdata),
        .dma_endpoint_select_i(ep_sel), .ep_state_i(ep_state),
        .ep_is_tx_i(is_tx), .ep_is_iso_i(is_iso),
        .automatic_transfer_mode_i(mode), .evt_i(evt),
        .count_done_flag_o(cdone), .transfer_error_flag_o(terr),
        .automatic_transfer_mode_stop_o(stop), .refill_o(refill), .flush_o(flush),
        .iso_drop_o(drop), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
        .rx_ready_o(rx_ready), .dma_data_o(dma_data),
        .dma_valid_o(dma_valid), .dma_ready_i(dma_ready)
    );

    uadma_host_model i_host (
        .clk_i(clk_i), .nrst_i(nrst_i), .start_i(start), .len_i(5'd16),
        .base_i(base), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .busy_o(busy)
    );

    // ------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------
    task automatic cmp8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp6(input string nm, input logic [5:0] e,
                        input logic [5:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Oldest note is taken whenever a result shows at the outputs
    always @(posedge clk_i)
    begin
        if (rd_look)
            cmp8("rdata", rd_q.pop_front(), rdata);
        if (pulses !== 6'h00)
            cmp6("events", (ev_q.size() > 0) ? ev_q.pop_front() : 6'h00,
                 pulses);
        if (dma_valid === 1'b1 && dma_ready === 1'b1)
            cmp8("dma_data", (dma_q.size() > 0) ? dma_q.pop_front()
                 : ~dma_data, dma_data);
    end

    // Random stalls on the drain side
    always @(negedge clk_i)
        dma_ready <= 1'($urandom_range(0, 1));

    // Watchdog well beyond the expected run length
    initial
    begin
        #100000;
        err_count++;
        final_report();
    end

    // ------------------------------------------------------
    // Drivers: one request cycle, then one idle cycle
    // ------------------------------------------------------
    task automatic drv(input logic [1:0] wrrd, input logic [1:0] sel,
                       input logic [7:0] d, input logic [2:0] e);
        @(negedge clk_i);
        cpu = {wrrd, sel, d};
        evt = e;
        @(negedge clk_i);
        cpu = '0;
        evt = '0;
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        drv(2'b10, sel, d, 3'b000);
    endtask

    task automatic rd(input logic [1:0] sel, input logic [7:0] e);
        rd_q.push_back(e);
        drv(2'b01, sel, 8'h00, 3'b000);
        rd_look = 1'b1;
        @(negedge clk_i);
        rd_look = 1'b0;
    endtask

    // Event bits are {pkt_ok, pkt_err, dma_done}
    task automatic ev(input logic [2:0] e, input logic [5:0] x);
        if (x != 6'h00)
            ev_q.push_back(x);
        drv(2'b00, 2'h0, 8'h00, e);
    endtask

    // Active copy lags the mode input by one cycle
    task automatic set_mode(input logic m);
        @(negedge clk_i);
        mode = m;
        repeat (2) @(negedge clk_i);
    endtask

    // ------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------
    initial
    begin
        void'($urandom(32'h9ac6bb64));
        nrst_i = 1'b0;
        cpu = '0;
        evt = '0;
        ep_sel = 3'h6;
        for (i = 0; i < 6; i++)
            ep_state[i] = 8'($urandom);
        {is_tx, is_iso, mode, start, rd_look, dma_ready} = '0;
        base = 8'($urandom);
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        // Reserved select keeps the reset echo
        rd(`UADMA_SEL_ECHO, `UADMA_ECHO_RST);
        rd(`UADMA_SEL_CNT, 8'h00);
        rd(`UADMA_SEL_ERR, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            ep_sel = 3'(i);
            repeat (2) @(negedge clk_i);
            rd(`UADMA_SEL_ECHO, ep_state[i]);
            wr(`UADMA_SEL_ECHO, ~ep_state[i]);
            rd(`UADMA_SEL_ECHO, ep_state[i]);
            ep_state[i] = 8'($urandom);
            repeat (2) @(negedge clk_i);
            rd(`UADMA_SEL_ECHO, ep_state[i]);
        end
        // Receive countdown: two packets programmed as one
        ep_sel = 3'h1;
        wr(`UADMA_SEL_CNT, 8'h01);
        set_mode(1'b1);
        ev(3'b001, 6'h00);
        rd(`UADMA_SEL_CNT, 8'h01);
        ev(3'b100, 6'h00);
        ev(3'b001, 6'h00);
        rd(`UADMA_SEL_CNT, 8'h00);
        ev(3'b100, 6'h00);
        ev(3'b001, 6'b101000);
        rd(`UADMA_SEL_CNT, 8'h00);
        set_mode(1'b0);
        // Transmit countdown and write against decrement
        is_tx = 1'b1;
        wr(`UADMA_SEL_CNT, 8'h02);
        set_mode(1'b1);
        ev(3'b001, 6'h00);
        ev(3'b100, 6'h00);
        rd(`UADMA_SEL_CNT, 8'h01);
        ev(3'b001, 6'h00);
        drv(2'b10, `UADMA_SEL_CNT, 8'h05, 3'b100);
        rd(`UADMA_SEL_CNT, 8'h05);
        set_mode(1'b0);
        // Retry counter with handling on, two attempts
        is_tx = 1'b0;
        wr(`UADMA_SEL_ERR, 8'h81);
        rd(`UADMA_SEL_ERR, 8'h81);
        set_mode(1'b1);
        wr(`UADMA_SEL_ERR, 8'h05);
        ev(3'b010, 6'b000010);
        rd(`UADMA_SEL_ERR, 8'h80);
        ev(3'b010, 6'b011000);
        rd(`UADMA_SEL_ERR, 8'h80);
        set_mode(1'b0);
        rd(`UADMA_SEL_ERR, 8'h81);
        set_mode(1'b1);
        rd(`UADMA_SEL_ERR, 8'h81);
        is_tx = 1'b1;
        ev(3'b010, 6'b000100);
        ev(3'b100, 6'h00);
        rd(`UADMA_SEL_ERR, 8'h81);
        is_tx = 1'b0;
        is_iso = 1'b1;
        ev(3'b010, 6'b000011);
        set_mode(1'b0);
        // Handling off: no action, flag at once
        wr(`UADMA_SEL_ERR, 8'h03);
        set_mode(1'b1);
        ev(3'b010, 6'b011000);
        rd(`UADMA_SEL_ERR, 8'h03);
        set_mode(1'b0);
        // Iso receive data: bad packet dropped, full packet passed
        wr(`UADMA_SEL_ERR, 8'h81);
        set_mode(1'b1);
        for (int p = 0; p < 2; p++)
        begin
            base = 8'($urandom);
            @(negedge clk_i);
            start = 1'b1;
            @(negedge clk_i);
            start = 1'b0;
            for (i = 0; i < 300 && busy; i++)
                @(negedge clk_i);
            repeat (3) @(negedge clk_i);
            cmp8("rx_ready_full", 8'h00, 8'(rx_ready));
            if (p == 0)
                ev(3'b010, 6'b000011);
            else
            begin
                for (i = 0; i < 16; i++)
                    dma_q.push_back(base + 8'(i));
                ev(3'b100, 6'h00);
            end
            for (i = 0; i < 400 && dma_q.size() > 0; i++)
                @(negedge clk_i);
        end
        repeat (10) @(negedge clk_i);
        cmp8("dma_left", 8'h00, 8'(dma_q.size()));
        cmp8("ev_left", 8'h00, 8'(ev_q.size()));
        final_report();
    end
endmodule // testbench
`default_nettype wire
